//--- core/plg_i2c_slave.sv
`timescale 1ns/1ps
module plg_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  output plg_pkg::plg_acc_t acc_out,
  output logic [7:0] ptr_out,
  input wire logic [7:0] rdata_in
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_WAIT, ST_ACK, ST_WRITE, ST_READ, ST_RACK,
    ST_RWAIT
  } plg_i2c_st_t;

  plg_i2c_st_t state;
  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic is_read, first;

  wire rise = scl_s2 & ~scl_q;
  wire fall = ~scl_s2 & scl_q;
  wire start_c = scl_s2 & scl_q & sda_q & ~sda_s2;
  wire stop_c = scl_s2 & scl_q & ~sda_q & sda_s2;
  wire [7:0] byte_in = {shreg[6:0], sda_s2};
  wire byte_done = rise & (bit_cnt == 3'h7);

  always_ff @(posedge clk_in)
  begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_q <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_q <= sda_s2;
  end

  always_ff @(posedge clk_in)
  begin
    acc_out <= '0;
    if (srst_in)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      first <= 1'b0;
      ptr_out <= 8'h00;
      sda_oe_out <= 1'b0;
    end
    else if (start_c)
    begin
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      first <= 1'b1;
      sda_oe_out <= 1'b0;
    end
    else if (stop_c)
    begin
      state <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end
    else
    begin
      case (state)
        ST_ADDR, ST_WRITE:
          if (rise)
          begin
            shreg <= byte_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done && state == ST_ADDR)
            begin
              is_read <= sda_s2;
              state <= (byte_in[7:1] == DEV_ADDR) ? ST_ACK_WAIT : ST_IDLE;
            end
            else if (byte_done)
            begin
              // a pointer byte is itself an access: commands live here
              acc_out <= '{wr: ~first, cmd: first, addr: first ?
                byte_in : ptr_out, data: byte_in};
              ptr_out <= first ? byte_in : ptr_out + 8'h01;
              first <= 1'b0;
              state <= ST_ACK_WAIT;
            end
          end
        ST_ACK_WAIT:
          if (fall)
          begin
            sda_oe_out <= 1'b1;
            state <= ST_ACK;
          end
        ST_ACK, ST_RWAIT:
          if (fall)
          begin
            bit_cnt <= 3'h0;
            if (is_read)
            begin
              shreg <= rdata_in;
              ptr_out <= ptr_out + 8'h01;
              sda_oe_out <= ~rdata_in[7];
              state <= ST_READ;
            end
            else
            begin
              sda_oe_out <= 1'b0;
              state <= ST_WRITE;
            end
          end
        ST_READ:
          if (fall)
          begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg <= {shreg[6:0], 1'b0};
            sda_oe_out <= (bit_cnt == 3'h7) ? 1'b0 : ~shreg[6];
            if (bit_cnt == 3'h7)
              state <= ST_RACK;
          end
        ST_RACK:
          if (rise)
            state <= sda_s2 ? ST_IDLE : ST_RWAIT;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule : plg_i2c_slave

//--- core/plg_pkg.sv
package plg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PULSE = 8'h8e;
  localparam logic [7:0] ADDR_CTRL = 8'h8f;
  localparam logic [7:0] ADDR_CFG2 = 8'h90;
  localparam logic [7:0] ADDR_CLR_PROX = 8'he5;
  localparam logic [7:0] ADDR_CLR_CLEAR = 8'he6;
  localparam logic [7:0] ADDR_CLR_ALL = 8'he7;

  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CFG2 = 8'h01;

  // ----------------------------------------------------------------
  // field layouts, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] width;
    logic [5:0] count;
  } plg_pulse_t;

  typedef struct packed {
    logic [1:0] drive;
    logic route;
    logic invert;
    logic [1:0] prox_gain;
    logic [1:0] cgain;
  } plg_ctrl_t;

  typedef struct packed {
    logic prox_sat_irq_en;
    logic clear_sat_irq_en;
    logic [1:0] boost;
    logic [3:0] rsvd;
  } plg_cfg2_t;

  // one host access decoded by the serial slave
  typedef struct packed {
    logic wr;
    logic cmd;
    logic [7:0] addr;
    logic [7:0] data;
  } plg_acc_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int BASE_WIDTH_NS = 4000;
  localparam int LED_EXT_PS = 1360000;
  localparam int PULSE_GAP_NS = 4000;
  localparam int BASE_CYC = BASE_WIDTH_NS * CLK_MHZ / 1000;
  localparam int EXT_CYC = (LED_EXT_PS * CLK_MHZ + 999999) / 1000000;
  localparam int GAP_CYC = PULSE_GAP_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 13;

  // drive scale in eighths of nominal: full drive is 8
  localparam logic [3:0] DRIVE_FULL = 4'h8;

endpackage : plg_pkg

//--- core/plg_regs.sv
`timescale 1ns/1ps
module plg_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic prox_burst_start_in,
  input wire logic prox_sat_event_in,
  input wire logic clear_sat_event_in,
  input wire logic prox_engine_on_in,
  input wire logic color_engine_on_in,
  output logic led_drive_pin_out,
  output logic prox_integrate_out,
  output logic prox_burst_busy_out,
  output logic [5:0] led_current_level_out,
  output logic [3:0] prox_gain_out,
  output logic [6:0] color_gain_out,
  output logic prox_sat_flag_out,
  output logic clear_sat_flag_out,
  output logic irq_n_out
);

  typedef enum logic [1:0] {PS_IDLE, PS_ON, PS_GAP} plg_pstate_t;

  function automatic logic [12:0] on_cycles(input logic [1:0] w);
    on_cycles = 13'(plg_pkg::BASE_CYC << w) + 13'(plg_pkg::EXT_CYC);
  endfunction : on_cycles

  function automatic logic [12:0] int_cycles(input logic [1:0] w);
    int_cycles = 13'(plg_pkg::BASE_CYC << w);
  endfunction : int_cycles

  // ----------------------------------------------------------------
  // host access
  // ----------------------------------------------------------------
  plg_pkg::plg_acc_t acc;
  plg_pkg::plg_pulse_t pulse_r;
  plg_pkg::plg_ctrl_t ctrl_r;
  plg_pkg::plg_cfg2_t cfg2_r;
  logic [7:0] ptr;
  logic [7:0] rdata;

  plg_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .acc_out(acc),
    .ptr_out(ptr),
    .rdata_in(rdata)
  );

  assign sda_out = 1'b0;

  wire hit_pulse = ptr == plg_pkg::ADDR_PULSE;
  wire hit_ctrl = ptr == plg_pkg::ADDR_CTRL;
  wire hit_cfg2 = ptr == plg_pkg::ADDR_CFG2;
  // unmapped addresses read as zero
  assign rdata = hit_pulse ? pulse_r :
                 hit_ctrl ? ctrl_r :
                 hit_cfg2 ? cfg2_r : 8'h00;

  wire acc_any = acc.wr | acc.cmd;
  wire clr_prox = acc_any & (acc.addr == plg_pkg::ADDR_CLR_PROX ||
                             acc.addr == plg_pkg::ADDR_CLR_ALL);
  wire clr_clear = acc_any & (acc.addr == plg_pkg::ADDR_CLR_CLEAR ||
                              acc.addr == plg_pkg::ADDR_CLR_ALL);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pulse_r <= plg_pkg::RST_PULSE;
      ctrl_r <= plg_pkg::RST_CTRL;
      cfg2_r <= plg_pkg::RST_CFG2;
    end
    else if (acc.wr)
    begin
      // reserved bits stored as written; keeping them is up to the host
      if (acc.addr == plg_pkg::ADDR_PULSE)
        pulse_r <= acc.data;
      else if (acc.addr == plg_pkg::ADDR_CTRL)
        ctrl_r <= acc.data;
      else if (acc.addr == plg_pkg::ADDR_CFG2)
        cfg2_r <= acc.data;
    end
  end

  // ----------------------------------------------------------------
  // saturation flags and interrupt pin
  // ----------------------------------------------------------------
  // a saturation event wins over a clear in the same cycle
  wire next_prox_flag = prox_sat_event_in |
    (prox_sat_flag_out & ~clr_prox & prox_engine_on_in);
  wire next_clear_flag = clear_sat_event_in |
    (clear_sat_flag_out & ~clr_clear & color_engine_on_in);
  wire irq_req = (prox_sat_flag_out & cfg2_r.prox_sat_irq_en) |
                 (clear_sat_flag_out & cfg2_r.clear_sat_irq_en);

  // ----------------------------------------------------------------
  // led pulse burst
  // ----------------------------------------------------------------
  plg_pstate_t pstate, next_pstate;
  logic [12:0] cnt, next_cnt;
  logic [5:0] left, next_left;
  logic [1:0] wsel, next_wsel;

  always_comb
  begin
    next_pstate = pstate;
    next_cnt = cnt + 13'h1;
    next_left = left;
    next_wsel = wsel;
    case (pstate)
      PS_IDLE:
      begin
        next_cnt = 13'h0;
        if (prox_burst_start_in)
        begin
          next_pstate = PS_ON;
          next_left = pulse_r.count;
          next_wsel = pulse_r.width;
        end
      end
      PS_ON:
        if (cnt == on_cycles(wsel) - 13'h1)
        begin
          next_cnt = 13'h0;
          next_pstate = (left == 6'h0) ? PS_IDLE : PS_GAP;
        end
      PS_GAP:
        if (cnt == 13'(plg_pkg::GAP_CYC - 1))
        begin
          next_cnt = 13'h0;
          next_left = left - 6'h1;
          next_pstate = PS_ON;
        end
      default:
        next_pstate = PS_IDLE;
    endcase
  end

  wire next_led = next_pstate == PS_ON;
  wire next_integ = next_led & (next_cnt < int_cycles(next_wsel));

  // current in sixteenths of nominal: drive scale times boost halves
  wire [3:0] drive_base = plg_pkg::DRIVE_FULL >> ctrl_r.drive;
  wire [2:0] boost_half = (cfg2_r.boost == 2'h3) ? 3'h6 :
                          3'(cfg2_r.boost) + 3'h2;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pstate <= PS_IDLE;
      cnt <= 13'h0;
      left <= 6'h0;
      wsel <= 2'h0;
      led_drive_pin_out <= 1'b0;
      prox_integrate_out <= 1'b0;
      prox_burst_busy_out <= 1'b0;
      led_current_level_out <= 6'h0;
      prox_gain_out <= 4'h1;
      color_gain_out <= 7'h01;
      prox_sat_flag_out <= 1'b0;
      clear_sat_flag_out <= 1'b0;
      irq_n_out <= 1'b1;
    end
    else
    begin
      pstate <= next_pstate;
      cnt <= next_cnt;
      left <= next_left;
      wsel <= next_wsel;
      led_drive_pin_out <= next_led;
      prox_integrate_out <= next_integ;
      prox_burst_busy_out <= next_pstate != PS_IDLE;
      // widen first: 8 x 6 overflows a 4-bit product
      led_current_level_out <= 6'(drive_base) * 6'(boost_half);
      prox_gain_out <= 4'h1 << ctrl_r.prox_gain;
      color_gain_out <= 7'h01 << {ctrl_r.cgain, 1'b0};
      prox_sat_flag_out <= next_prox_flag;
      clear_sat_flag_out <= next_clear_flag;
      // routed pattern follows the led pin; otherwise active-low request
      irq_n_out <= ctrl_r.route ? (next_led ^ ctrl_r.invert)
                                : ~irq_req;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  logic [6:0] rise_cnt;
  logic [5:0] burst_total;
  logic led_q;
  // count latched apart from the design's own down-counter
  always_ff @(posedge clk_in)
  begin
    led_q <= led_drive_pin_out;
    if (pstate == PS_IDLE)
      burst_total <= pulse_r.count;
    if (srst_in || pstate == PS_IDLE)
      rise_cnt <= 7'h0;
    else if (led_drive_pin_out & ~led_q)
      rise_cnt <= rise_cnt + 7'h1;
  end

  chk_pulse_total: assert property (
    $fell(prox_burst_busy_out) |-> rise_cnt == 7'(burst_total) + 7'h1)
    else $error("burst ended with wrong pulse count");
  chk_integ_within_led: assert property (
    prox_integrate_out |-> led_drive_pin_out)
    else $error("integration outside led pulse");
  chk_led_tail: assert property (
    $fell(prox_integrate_out) && pstate == PS_ON |->
      led_drive_pin_out [*8])
    else $error("led dropped with integration");
  chk_width_min: assert property (
    $rose(prox_integrate_out) |-> prox_integrate_out [*8])
    else $error("integration pulse too short");
  chk_route_copy: assert property (
    ctrl_r.route |=>
      irq_n_out == (led_drive_pin_out ^ $past(ctrl_r.invert)))
    else $error("irq pin does not follow led");
  chk_prox_irq_gate: assert property (
    !ctrl_r.route && prox_sat_flag_out && $stable(cfg2_r) &&
      cfg2_r.prox_sat_irq_en |=> !irq_n_out)
    else $error("prox saturation irq missing");
  chk_irq_quiet: assert property (
    !ctrl_r.route && !cfg2_r.prox_sat_irq_en && !cfg2_r.clear_sat_irq_en && $stable(cfg2_r)
      && $stable(ctrl_r) |=> irq_n_out)
    else $error("irq raised while disabled");
  chk_clear_cmd: assert property (
    clr_prox && !prox_sat_event_in |=> !prox_sat_flag_out)
    else $error("prox flag survived clear");
  chk_clear_chan: assert property (
    clr_clear && !clear_sat_event_in |=> !clear_sat_flag_out)
    else $error("clear flag survived clear");
  chk_event_wins: assert property (
    prox_sat_event_in |=> prox_sat_flag_out)
    else $error("saturation event lost");
  chk_current_full: assert property (
    ctrl_r.drive == 2'h0 && cfg2_r.boost == 2'h3 && $stable(ctrl_r) &&
      $stable(cfg2_r) |=> led_current_level_out == 6'h30)
    else $error("boosted current wrong");
  chk_color_gain: assert property (
    ctrl_r.cgain == 2'h3 && $stable(ctrl_r) |=> color_gain_out == 7'h40)
    else $error("colour gain wrong");

  cov_burst: cover property ($fell(prox_burst_busy_out));
  cov_routed: cover property (ctrl_r.route && $rose(led_drive_pin_out));
  cov_sat_irq: cover property ($fell(irq_n_out) && !ctrl_r.route);

endmodule : plg_regs

//--- test/plg_host.sv
`timescale 1ns/1ps
module plg_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // ----------------------------------------------------------------
  // serial host, 8 clk per hold step (scl high 8, low 16), twice the minimum
  // ----------------------------------------------------------------
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic hold;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : hold

  // sda moves only mid low phase, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    hold;
    sda_oe_out = ~b;
    hold;
    scl_out = 1'b1;
    hold;
    s = sda_in;
    scl_out = 1'b0;
  endtask : bit_io

  task automatic start;
    hold;
    sda_oe_out = 1'b0;
    hold;
    scl_out = 1'b1;
    hold;
    sda_oe_out = 1'b1;
    hold;
    scl_out = 1'b0;
  endtask : start

  task automatic stop;
    hold;
    sda_oe_out = 1'b1;
    hold;
    scl_out = 1'b1;
    hold;
    sda_oe_out = 1'b0;
    hold;
  endtask : stop

  // last = 1 releases sda in the ninth bit (nack when reading)
  task automatic byte_io(input logic [7:0] b, input logic last,
                         output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(last, a);
    ack = ~a;
  endtask : byte_io
endmodule : plg_host

//--- test/plg_regs_test.sv
`timescale 1ns/1ps
module plg_regs_test;
  localparam logic [6:0] DEV = 7'h2a;  // arbitrary
  logic clk_in;
  logic srst_in;
  logic burst_start;
  logic prox_evt;
  logic clear_evt;
  logic prox_on;
  logic color_on;
  logic scl;
  logic host_oe;
  logic dut_oe;
  logic sda;
  logic led, integ, busy, psf, csf, irq_n, led_q, int_q, route_chk, inv;
  logic [5:0] cur;
  logic [3:0] pg;
  logic [6:0] cg;
  logic [7:0] rd, c, g;
  logic ack;
  int bad_count, tests_run, cyc, pulses, on_cnt, on_len, int_cnt, int_len;
  int route_err;
  int mult [4] = '{2, 3, 4, 6};

  // pull-up on the open-drain data line
  assign sda = ~(host_oe | dut_oe);
  always #4 clk_in = ~clk_in;

  plg_regs #(.DEV_ADDR(DEV)) plg_regs_i (
    .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(dut_oe), .prox_burst_start_in(burst_start),
    .prox_sat_event_in(prox_evt), .clear_sat_event_in(clear_evt),
    .prox_engine_on_in(prox_on), .color_engine_on_in(color_on),
    .led_drive_pin_out(led), .prox_integrate_out(integ),
    .prox_burst_busy_out(busy), .led_current_level_out(cur),
    .prox_gain_out(pg), .color_gain_out(cg), .prox_sat_flag_out(psf),
    .clear_sat_flag_out(csf), .irq_n_out(irq_n));
  plg_host plg_host_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(host_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task automatic send(input logic [7:0] b);
    plg_host_i.byte_io(b, 1'b1, rd, ack);
    check(16'(ack), 16'h1);
  endtask : send

  task automatic reg_wr(input logic [7:0] ptr, input int n,
                        input logic [7:0] d0, d1, d2);
    logic [7:0] d [3];
    d = '{d0, d1, d2};
    plg_host_i.start;
    send({DEV, 1'b0});
    send(ptr);
    for (int i = 0; i < n; i++)
      send(d[i]);
    plg_host_i.stop;
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] v;
    plg_host_i.start;
    send({DEV, 1'b0});
    send(ptr);
    plg_host_i.start;
    send({DEV, 1'b1});
    plg_host_i.byte_io(8'hff, 1'b1, v, ack);
    plg_host_i.stop;
    check(16'(v), 16'(exp));
  endtask : rd_chk

  task automatic evt(input logic p, input logic q);
    prox_evt = p;
    clear_evt = q;
    step(1);
    prox_evt = 1'b0;
    clear_evt = 1'b0;
    step(2);
  endtask : evt

  task automatic flags(input logic p, input logic q, input logic i);
    check(16'({psf, csf, irq_n}), 16'({p, q, i}));
  endtask : flags

  // ----------------------------------------------------------------
  // pulse monitor, sampled mid-cycle away from the launching edge
  // ----------------------------------------------------------------
  always @(negedge clk_in)
  begin
    cyc++;
    if (led && !led_q)
      pulses++;
    if (led)
      on_cnt++;
    else if (led_q)
    begin
      on_len = on_cnt;
      on_cnt = 0;
    end
    if (integ)
      int_cnt++;
    else if (int_q)
    begin
      int_len = int_cnt;
      int_cnt = 0;
    end
    if (route_chk && irq_n !== (led ^ inv))
      route_err++;
    led_q = led;
    int_q = integ;
    if (cyc == 90000)
    begin
      bad_count++;
      conclude;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {clk_in, burst_start, prox_evt, clear_evt, route_chk, inv} = '0;
    {srst_in, prox_on, color_on} = 3'b111;
    {led_q, int_q} = '0;
    {bad_count, tests_run, cyc, on_cnt, on_len, int_cnt, int_len} = '0;
    repeat (6) @(posedge clk_in);
    #1;
    srst_in = 1'b0;
    step(3);
    check(16'({led, busy, irq_n}), 16'h1);
    check(16'(cur), 16'h0010);
    check(16'({pg, cg}), 16'({4'h1, 7'h01}));
    rd_chk(plg_pkg::ADDR_PULSE, plg_pkg::RST_PULSE);
    rd_chk(plg_pkg::ADDR_CTRL, plg_pkg::RST_CTRL);
    rd_chk(plg_pkg::ADDR_CFG2, plg_pkg::RST_CFG2);
    rd_chk(8'h55, 8'h00);
    plg_host_i.start;
    plg_host_i.byte_io({~DEV, 1'b0}, 1'b1, rd, ack);
    plg_host_i.stop;
    check(16'(ack), 16'h0);
    // every drive, boost and gain code, via an auto-incrementing write
    for (int i = 0; i < 4; i++)
    begin
      c = {2'(i), 2'b00, 2'(i), 2'(i)};
      g = {2'b00, 2'(3 - i), 4'h1};
      reg_wr(plg_pkg::ADDR_PULSE, 3, 8'h00, c, g);
      step(4);
      check(16'(pg), 16'(1 << i));
      check(16'(cg), 16'(1 << (2 * i)));
      check(16'(cur), 16'((8 >> i) * mult[3 - i]));
      rd_chk(plg_pkg::ADDR_CTRL, c);
      rd_chk(plg_pkg::ADDR_CFG2, g);
    end
    // every width, routing and inversion, with a refused second start
    for (int i = 0; i < 4; i++)
    begin
      c = {2'b00, i[0], i[1], 4'h0};
      reg_wr(plg_pkg::ADDR_PULSE, 3, {2'(i), 6'(3 - i)}, c, 8'h01);
      step(4);
      pulses = 0;
      route_err = 0;
      route_chk = i[0];
      inv = i[1];
      burst_start = 1'b1;
      step(1);
      burst_start = 1'b0;
      step(5);
      check(16'(busy), 16'h1);
      burst_start = 1'b1;
      step(1);
      burst_start = 1'b0;
      for (int k = 0; k < 40000 && busy === 1'b1; k++)
        step(1);
      route_chk = 1'b0;
      step(2);
      check(16'(pulses), 16'(4 - i));
      check(16'(int_len), 16'(plg_pkg::BASE_CYC << i));
      check(16'(on_len - int_len), 16'(plg_pkg::EXT_CYC));
      check(16'(route_err), 16'h0);
    end
    reg_wr(plg_pkg::ADDR_PULSE, 3, 8'h00, 8'h00, 8'h81);
    evt(1'b1, 1'b0);
    flags(1'b1, 1'b0, 1'b0);
    reg_wr(plg_pkg::ADDR_CLR_PROX, 0, 8'h00, 8'h00, 8'h00);
    flags(1'b0, 1'b0, 1'b1);
    evt(1'b0, 1'b1);
    flags(1'b0, 1'b1, 1'b1);
    reg_wr(plg_pkg::ADDR_CFG2, 1, 8'h41, 8'h00, 8'h00);
    flags(1'b0, 1'b1, 1'b0);
    evt(1'b1, 1'b0);
    reg_wr(plg_pkg::ADDR_CLR_CLEAR, 0, 8'h00, 8'h00, 8'h00);
    flags(1'b1, 1'b0, 1'b1);
    evt(1'b0, 1'b1);
    reg_wr(plg_pkg::ADDR_CLR_ALL, 0, 8'h00, 8'h00, 8'h00);
    flags(1'b0, 1'b0, 1'b1);
    evt(1'b1, 1'b1);
    prox_on = 1'b0;
    step(2);
    flags(1'b0, 1'b1, 1'b0);
    color_on = 1'b0;
    step(2);
    flags(1'b0, 1'b0, 1'b1);
    conclude;
  end
endmodule : plg_regs_test
